// ===== verilog/iocld_pkg.sv
package iocld_pkg;

  localparam int unsigned ADDR_W = 16;

  typedef logic [ADDR_W-1:0] iocld_addr_t;

  // Inclusive address window
  typedef struct packed {
    iocld_addr_t lo;
    iocld_addr_t hi;
  } iocld_range_s;

  // Host I/O request as it enters the decoder
  typedef struct packed {
    logic        valid;
    logic        write;
    iocld_addr_t addr;
    logic [7:0]  data;
  } iocld_req_s;

  typedef enum logic [1:0] {
    IOCLD_TGT_NONE = 2'b00,
    IOCLD_TGT_LPC  = 2'b01,
    IOCLD_TGT_PCIE = 2'b10
  } iocld_tgt_e;

  // Routed cycle as it leaves the decoder
  typedef struct packed {
    logic        valid;
    iocld_tgt_e  target;
    logic        write;
    iocld_addr_t addr;
    logic [7:0]  data;
    logic        onmod;
    logic        pnp;
  } iocld_route_s;

  localparam int unsigned N_RANGES = 26;

  localparam iocld_range_s LPC_RANGES [N_RANGES] = '{
    '{16'h002E, 16'h002F}, '{16'h004E, 16'h004F},
    '{16'h0060, 16'h0060}, '{16'h0064, 16'h0064},
    '{16'h0220, 16'h0227}, '{16'h0228, 16'h022F},
    '{16'h0230, 16'h0233}, '{16'h0238, 16'h023F},
    '{16'h0240, 16'h0253}, '{16'h0260, 16'h0273},
    '{16'h0278, 16'h027F}, '{16'h0280, 16'h0293},
    '{16'h02E8, 16'h02EF}, '{16'h02F8, 16'h02FF},
    '{16'h0338, 16'h033F}, '{16'h0378, 16'h037F},
    '{16'h03BC, 16'h03BF}, '{16'h03E8, 16'h03EF},
    '{16'h03F8, 16'h03FF}, '{16'h0678, 16'h067F},
    '{16'h0778, 16'h077F}, '{16'h07BC, 16'h07BF},
    '{16'h0A00, 16'h0BFF}, '{16'h0E00, 16'h0FFF},
    '{16'h0000, 16'h0000}, '{16'h0000, 16'h0000}
  };

  // Last two entries are unused padding; only this many are live
  localparam int unsigned N_LIVE = 24;

  localparam iocld_range_s ONMOD_RANGE = '{16'h0E38, 16'h0EBF};
  localparam iocld_addr_t  PNP_TOP     = 16'hFFF0;

endpackage : iocld_pkg

// ===== verilog/iocld_decoder.sv
// Contract
// - Any I/O cycle no listed range claims goes to the PCI Express side.
// - Forward 2Eh-2Fh, 4Eh-4Fh, 60h and 64h to LPC.
// - Forward 220h-227h, 228h-22Fh, 230h-233h to LPC, bounds inclusive.
// - Forward 238h-23Fh, 240h-253h, 260h-273h to LPC, bounds inclusive.
// - Forward 278h-27Fh, 280h-293h, 2E8h-2EFh to LPC, bounds inclusive.
// - Forward 2F8h-2FFh, 338h-33Fh, 378h-37Fh to LPC, bounds inclusive.
// - Forward 3BCh-3BFh, 3E8h-3EFh, 3F8h-3FFh to LPC, bounds inclusive.
// - Forward 678h-67Fh, 778h-77Fh, 7BCh-7BFh to LPC, bounds inclusive.
// - Forward wide windows A00h-BFFh and E00h-FFFh to LPC.
// - E38h-EBFh is always held by on-module LPC devices.
`timescale 1ns/1ns

module iocld_decoder (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire iocld_pkg::iocld_req_s  req,
  output logic                        req_ready,
  output iocld_pkg::iocld_route_s     route_q
);

  // One register stage: the whole decision is made from the address as
  // presented, so a cycle is never split across two lookups.
  // The cost is one cycle of latency on every routed cycle,
  // LPC and PCI Express alike.

  // Window groups as they stand in the shared range table, one per rule;
  // keep these in step with the table order
  localparam int unsigned N_GRP = 8;
  localparam int unsigned GRP_FIRST [N_GRP] = '{0, 4, 7, 10, 13, 16, 19, 22};
  localparam int unsigned GRP_LAST  [N_GRP] = '{3, 6, 9, 12, 15, 18, 21, 23};

  // Both bounds inclusive, so single ports are windows with lo equal to hi
  function automatic logic in_range(
    input iocld_pkg::iocld_addr_t  a,
    input iocld_pkg::iocld_range_s r
  );
    logic lo_ok;
    logic hi_ok;
    lo_ok    = (a >= r.lo);
    hi_ok    = (a <= r.hi);
    in_range = lo_ok && hi_ok;
  endfunction : in_range

  // Selects the table entries that belong to one rule group
  function automatic logic [iocld_pkg::N_LIVE-1:0] grp_mask(
    input int unsigned g
  );
    grp_mask = '0;
    for (int unsigned i = 0; i < iocld_pkg::N_LIVE; i++)
    begin
      if ((i >= GRP_FIRST[g]) && (i <= GRP_LAST[g]))
      begin
        grp_mask[i] = 1'b1;
      end
    end
  endfunction : grp_mask

  logic [iocld_pkg::N_LIVE-1:0] hit;
  logic [N_GRP-1:0]             grp_hit;

  logic                         rl2_hit;
  logic                         rl3_hit;
  logic                         rl4_hit;
  logic                         rl5_hit;
  logic                         rl6_hit;
  logic                         rl7_hit;
  logic                         rl8_hit;
  logic                         rl9_hit;

  logic                         lpc_hit;
  logic                         onmod_hit;
  logic                         below_top;
  logic                         pnp_hit;
  iocld_pkg::iocld_tgt_e        target_d;
  iocld_pkg::iocld_route_s      route_d;

  // Registered copy of each field, one flop group per concern
  logic                         valid_q;
  iocld_pkg::iocld_tgt_e        target_q;
  logic                         write_q;
  iocld_pkg::iocld_addr_t       addr_q;
  logic [7:0]                   data_q;
  logic                         onmod_q;
  logic                         pnp_q;

  // Every listed window is compared in parallel on the full address;
  // no window depends on the result of another
  generate
    for (genvar i = 0; i < iocld_pkg::N_LIVE; i++)
    begin : g_win
      assign hit[i] = in_range(req.addr, iocld_pkg::LPC_RANGES[i]);
    end
  endgenerate

  // Reduce the window hits to one flag per rule group;
  // the padding entries of the table are never masked in
  generate
    for (genvar g = 0; g < N_GRP; g++)
    begin : g_grp
      assign grp_hit[g] = |(hit & grp_mask(g));
    end
  endgenerate

  // Super I/O configuration, keyboard and mouse ports
  assign rl2_hit = grp_hit[0];

  // Windows from 220h to 233h
  assign rl3_hit = grp_hit[1];

  // Windows from 238h to 273h
  assign rl4_hit = grp_hit[2];

  // Windows from 278h to 2EFh
  assign rl5_hit = grp_hit[3];

  // Windows from 2F8h to 37Fh
  assign rl6_hit = grp_hit[4];

  // Windows from 3BCh to 3FFh
  assign rl7_hit = grp_hit[5];

  // Windows from 678h to 7BFh
  assign rl8_hit = grp_hit[6];

  // Wide windows at A00h and E00h
  assign rl9_hit = grp_hit[7];

  // Any positive claim sends the cycle to LPC;
  // the groups overlap nowhere, so their order is of no account
  assign lpc_hit = rl2_hit | rl3_hit | rl4_hit | rl5_hit |
                   rl6_hit | rl7_hit | rl8_hit | rl9_hit;

  // Lies inside the E00h-FFFh window, so it always reaches LPC;
  // it is also forced there below, should that window ever shrink
  assign onmod_hit = in_range(req.addr, iocld_pkg::ONMOD_RANGE);

  // Flag only: the decoder cannot police allocation, it marks the region
  // Addresses above the allocation top are left unflagged
  assign below_top = (req.addr <= iocld_pkg::PNP_TOP);
  assign pnp_hit   = below_top && !lpc_hit;

  // Any LPC claim wins over the subtractive default in the same cycle;
  // an idle input routes nowhere
  always_comb
  begin
    if (!req.valid)
    begin
      target_d = iocld_pkg::IOCLD_TGT_NONE;
    end
    else if (lpc_hit || onmod_hit)
    begin
      target_d = iocld_pkg::IOCLD_TGT_LPC;
    end
    else
    begin
      target_d = iocld_pkg::IOCLD_TGT_PCIE;
    end
  end

  // Next value of the routed cycle;
  // the address and payload pass untouched
  always_comb
  begin
    route_d        = '0;
    route_d.valid  = req.valid;
    route_d.target = target_d;
    route_d.write  = req.write;
    route_d.addr   = req.addr;
    route_d.data   = req.data;
    route_d.onmod  = onmod_hit;
    route_d.pnp    = pnp_hit;
  end

  // Valid follows the request every cycle;
  // the decoder never stalls, so nothing is held back
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      valid_q <= 1'b0;
    end
    else
    begin
      valid_q <= route_d.valid;
    end
  end

  // Target is cleared in reset so no far side sees a stray claim
  // while the host interface is still settling
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      target_q <= iocld_pkg::IOCLD_TGT_NONE;
    end
    else
    begin
      target_q <= route_d.target;
    end
  end

  // Direction of the cycle;
  // meaningful only while valid is high
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      write_q <= 1'b0;
    end
    else
    begin
      write_q <= route_d.write;
    end
  end

  // Full address is passed on;
  // the far side decodes its own port within the window
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      addr_q <= '0;
    end
    else
    begin
      addr_q <= route_d.addr;
    end
  end

  // Write payload travels with the cycle;
  // read data returns on a path outside this block
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      data_q <= '0;
    end
    else
    begin
      data_q <= route_d.data;
    end
  end

  // Marks the span held by the on-module devices;
  // carrier-side devices must not be placed there
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      onmod_q <= 1'b0;
    end
    else
    begin
      onmod_q <= route_d.onmod;
    end
  end

  // Informational only;
  // allocation itself is done by the host, not here
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pnp_q <= 1'b0;
    end
    else
    begin
      pnp_q <= route_d.pnp;
    end
  end

  // Decoder never stalls; ready only drops in reset
  // and rises at the first edge after it
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      req_ready <= 1'b0;
    end
    else
    begin
      req_ready <= 1'b1;
    end
  end

  // Output is the flop group itself; nothing combinational follows it
  assign route_q = '{
    valid:  valid_q,
    target: target_q,
    write:  write_q,
    addr:   addr_q,
    data:   data_q,
    onmod:  onmod_q,
    pnp:    pnp_q
  };

endmodule : iocld_decoder

// ===== verification/iocld_decoder_props.sv
`timescale 1ns/1ns
module iocld_chk (
  input wire logic                    core_clk,
  input wire logic                    rst,
  input wire iocld_pkg::iocld_req_s   req,
  input wire logic                    req_ready,
  input wire iocld_pkg::iocld_route_s route_q
);
  wire [15:0] a = req.addr;
  wire [1:0]  t = route_q.target;
  wire        v = req.valid && req_ready;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_lat; v |=> route_q.valid && route_q.addr == $past(a); endproperty
  a_lat: assert property (p_lat) else $error("no answer");
  property p_idle; !req.valid |=> t == 2'h0; endproperty
  a_idle: assert property (p_idle) else $error("idle routed");
  property p_kbd; v && (a == 16'h0060 || a == 16'h0064) |=> t == 2'h1; endproperty
  a_kbd: assert property (p_kbd) else $error("kbd port");
  property p_gap; v && (a == 16'h0061 || a == 16'h0234) |=> t == 2'h2; endproperty
  a_gap: assert property (p_gap) else $error("gap claimed");
  property p_r3; v && a >= 16'h0220 && a <= 16'h0233 |=> t == 2'h1; endproperty
  a_r3: assert property (p_r3) else $error("r3");
  property p_r9; v && a >= 16'h0A00 && a <= 16'h0BFF |=> t == 2'h1; endproperty
  a_r9: assert property (p_r9) else $error("r9");
  property p_onm; v && a >= 16'h0E38 && a <= 16'h0EBF |=> route_q.onmod && t == 2'h1; endproperty
  a_onm: assert property (p_onm) else $error("onmod");
  property p_pnp; v && a == 16'h1000 |=> route_q.pnp && t == 2'h2; endproperty
  a_pnp: assert property (p_pnp) else $error("pnp");
endmodule : iocld_chk

// ===== verification/iocld_far_model.sv
`timescale 1ns/1ns
module iocld_far_model (
  input wire logic                    core_clk,
  input wire iocld_pkg::iocld_route_s route_q,
  output int                          n_lpc
);
  // Counts LPC cycles; the PCIe side silently takes the rest
  initial n_lpc = 0;
  always @(posedge core_clk)
    if (route_q.valid && route_q.target == iocld_pkg::IOCLD_TGT_LPC)
      n_lpc <= n_lpc + 1;
endmodule : iocld_far_model

// ===== verification/test_iocld_decoder.sv
`timescale 1ns/1ns
module test_iocld_decoder;
  logic [11:0] rng [40] = '{12'h02E, 12'h02F, 12'h04E, 12'h04F, 12'h060, 12'h060, 12'h064,
    12'h064, 12'h220, 12'h233, 12'h238, 12'h253, 12'h260, 12'h273, 12'h278, 12'h293, 12'h2E8,
    12'h2EF, 12'h2F8, 12'h2FF, 12'h338, 12'h33F, 12'h378, 12'h37F, 12'h3BC, 12'h3BF, 12'h3E8,
    12'h3EF, 12'h3F8, 12'h3FF, 12'h678, 12'h67F, 12'h778, 12'h77F, 12'h7BC, 12'h7BF, 12'hA00,
    12'hBFF, 12'hE00, 12'hFFF};
  logic                    core_clk = 0;
  logic                    rst = 1;
  iocld_pkg::iocld_req_s   req = '0;
  logic                    req_ready;
  iocld_pkg::iocld_route_s route_q;
  int                      err_count = 0;
  int                      checked = 0;
  int                      n_lpc;
  int                      cyc = 0;
  iocld_decoder dut_u (.core_clk(core_clk), .rst(rst), .req(req), .req_ready(req_ready),
    .route_q(route_q));
  iocld_far_model far_u (.core_clk(core_clk), .route_q(route_q), .n_lpc(n_lpc));
  initial forever #5 core_clk = ~core_clk;
  task automatic chk(input logic [29:0] seen, input logic [29:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic t_reset;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk) chk(30'(req_ready), 30'h0);
    @(posedge core_clk) rst <= 0;
    @(posedge core_clk);
    @(negedge core_clk) chk(30'(req_ready), 30'h1);
  endtask : t_reset
  // Probes one below, on and one above every bound in rng, plus on and just outside the on-module and PnP edges, back to back
  task automatic t_ranges;
    logic [15:0] q[$] = '{16'h0E37, 16'h0E38, 16'h0EBF, 16'h0EC0, 16'hFFF0, 16'hFFF1};
    logic [29:0] e[$];
    logic        l;
    int          np = 0;
    foreach (rng[k]) q = {q, 16'(rng[k]) - 16'h0001, 16'(rng[k]), 16'(rng[k]) + 16'h0001};
    for (int i = 0; i <= q.size(); i++)
    begin
      @(posedge core_clk);
      if (i < q.size())
      begin
        l = 0;
        for (int k = 0; k < 40; k += 2) l |= q[i] >= rng[k] && q[i] <= rng[k + 1];
        np += l;
        req <= {1'b1, i[0], q[i], i[7:0]};
        e.push_back({1'b1, l ? 2'h1 : 2'h2, i[0], q[i], i[7:0],
          q[i] >= 16'h0E38 && q[i] <= 16'h0EBF, !l && q[i] <= 16'hFFF0});
      end
      else
        req <= '0;
      @(negedge core_clk) if (i > 0) chk(route_q, e[i - 1]);
    end
    @(negedge core_clk) chk(30'({route_q.valid, route_q.target}), 30'h0);
    chk(30'(n_lpc), 30'(np));
  endtask : t_ranges
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_count++;
      tally_and_finish;
    end
  end
  initial
  begin
    t_reset;
    t_ranges;
    tally_and_finish;
  end
endmodule : test_iocld_decoder
bind iocld_decoder iocld_chk chk_u (.core_clk(core_clk), .rst(rst), .req(req),
  .req_ready(req_ready), .route_q(route_q));
